// File: rtl/hport_pkg.sv
// constants and types for the generic host port, used by the controller end only
// assumes: one 40 MHz clock (mclk_i) runs both ends and the bus clock strobe
`default_nettype none
package hport_pkg;
   // =========================================================
   // bus geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   // =========================================================
   // address map inside the 128K byte window
   localparam logic [16:0] MEM_LAST = 17'h1_3FFF;
   localparam logic [16:0] REG_FIRST = 17'h1_FFE0;
   localparam logic [16:0] REG_LAST = 17'h1_FFFF;
   // =========================================================
   // timing: clock period and refresh busy in ns, counts in core cycles
   localparam int CLK_NS = 25;
   localparam int REFRESH_BUSY_NS = 100;
   localparam int REFRESH_BUSY_CYC = (REFRESH_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = 2;
   // =========================================================
   // region decode result
   typedef enum logic [2:0]
   {
      RGN_MEM = 3'b001,
      RGN_REG = 3'b010,
      RGN_NONE = 3'b100
   } region_t;
   // decode a window offset into its region
   function automatic region_t region_of(input logic [16:0] a);
      if (a <= MEM_LAST)
         return RGN_MEM;
      else if (a >= REG_FIRST)
         return RGN_REG;
      else
         return RGN_NONE;
   endfunction
endpackage
`default_nettype wire

// File: rtl/hport_if.sv
// the host-bus wires between the glue-logic end and the controller end
// assumes: data lines resolved from the two output enables (low = driving)
`default_nettype none
interface hport_if;
   logic [16:0] host_address;
   logic host_cs_n;
   logic host_read_n;
   logic high_read_n;
   logic low_write_strobe;
   logic high_byte_strobe;
   logic wait_n;
   logic host_bus_clock_in;
   logic [15:0] dev_data_o;
   logic dev_data_oe_n;
   logic [15:0] host_data_o;
   logic host_data_oe_n;
   logic [15:0] host_data;
   // wired resolution of the shared data lines
   assign host_data = !dev_data_oe_n ? dev_data_o :
                      (!host_data_oe_n ? host_data_o : 16'hFFFF);
   modport dev
   (
      input host_address, host_cs_n, host_read_n, high_read_n,
      input low_write_strobe, high_byte_strobe, host_bus_clock_in,
      input host_data,
      output wait_n, dev_data_o, dev_data_oe_n
   );
   modport host
   (
      output host_address, host_cs_n, host_read_n, high_read_n,
      output low_write_strobe, high_byte_strobe, host_bus_clock_in,
      output host_data_o, host_data_oe_n,
      input host_data, wait_n
   );
endinterface
`default_nettype wire

// File: rtl/hport_dev.sv
// controller end of the generic host port: strap capture, strobe sync,
// region decode, refresh arbitration, wait and data drive
// assumes: a refresh engine asks for the shared resource on refresh_req_i
//
// What this block does
// - 16-bit data port, 17-bit address inputs
// - mode strap low one, high two
// - mode two: high read pin held high
// - mode one: byte write strobes, active low
// - mode one: byte read strobes, active low
// - active-low wait until data ready/taken
// - wait held through refresh arbitration
// - mode two: high-byte enable qualifies both
// - mode two: single write enable
// - mode two: single read enable
// - endian strap latched at reset
// - chip select decoded externally from address
// - dedicated bus clock paces transfers
// - memory 0-13FFFh, registers 1FFE0h-1FFFFh
// - asynchronous strobes synchronised internally
`default_nettype none
module hport_dev #(
   parameter int BUSY_CYC = hport_pkg::REFRESH_BUSY_CYC
)(
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // straps
   input wire logic bus_mode_strap_i,
   input wire logic endian_strap_i,
   // refresh contender
   input wire logic refresh_req_i,
   // internal resource side
   input wire logic [15:0] rd_word_i,
   output logic acc_o,
   output logic acc_we_o,
   output logic acc_reg_o,
   output logic [16:0] acc_addr_o,
   output logic [15:0] acc_wdata_o,
   output logic [1:0] acc_be_o,
   output logic mode_two_o,
   output logic big_endian_o,
   // host bus
   hport_if.dev bus
);
   // =========================================================
   // state
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_ARB = 5'b00010,
      ST_XFER = 5'b00100,
      ST_HOLD = 5'b01000,
      ST_DONE = 5'b10000
   } st_t;
   typedef struct packed
   {
      st_t st;
      logic strap_done;
      logic mode_two;
      logic big_endian;
      logic [2:0] sy1;    // first sync stage: cs, rd, wr (read by sy2 only)
      logic [2:0] sy2;
      logic [1:0] bclk_s; // bus clock sample pair
      logic is_rd;
      logic [1:0] be;
      logic [16:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [3:0] cnt;
      logic wait_n;
      logic oe_n;
      logic acc;
      logic acc_we;
      logic acc_reg;
   } dev_t;
   dev_t q, d;
   logic cs_a, rd_a, wr_a;
   logic cs_s, rd_s, wr_s;
   logic bclk_rise;
   hport_pkg::region_t rgn;

   // refuse a refresh tail that the 4-bit counter cannot hold
   if (BUSY_CYC < 1 || BUSY_CYC > 15)
   begin : g_busy_check
      $error("BUSY_CYC out of range");
   end

   // =========================================================
   // raw strobe decode per mode
   always_comb
   begin
      cs_a = !bus.host_cs_n;
      if (!q.mode_two)
      begin
         // mode one: byte strobes, either one starts the cycle
         rd_a = !bus.host_read_n || !bus.high_read_n;
         wr_a = !bus.low_write_strobe || !bus.high_byte_strobe;
      end
      else
      begin
         // mode two: high read pin is ignored, tied high by the far end
         rd_a = !bus.host_read_n;
         wr_a = !bus.low_write_strobe;
      end
   end
   assign cs_s = q.sy2[2];
   assign rd_s = q.sy2[1];
   assign wr_s = q.sy2[0];
   assign bclk_rise = q.bclk_s[0] && !q.bclk_s[1];
   assign rgn = hport_pkg::region_of(q.addr);

   // =========================================================
   // next state
   always_comb
   begin
      d = q;
      d.sy1 = {cs_a, rd_a, wr_a};
      d.sy2 = q.sy1;
      d.bclk_s = {q.bclk_s[0], bus.host_bus_clock_in};
      d.acc = 1'b0;
      if (!q.strap_done)
      begin
         // straps caught once, the first cycle after reset release
         d.strap_done = 1'b1;
         d.mode_two = bus_mode_strap_i;
         d.big_endian = endian_strap_i;
      end
      case (q.st)
         ST_IDLE:
         begin
            d.wait_n = 1'b1;
            d.oe_n = 1'b1;
            if (q.strap_done && cs_s && (rd_s ^ wr_s) && bclk_rise)
            begin
               d.is_rd = rd_s;
               d.addr = bus.host_address;
               d.wdata = bus.host_data;
               if (!q.mode_two)
                  d.be = rd_s ? {!bus.high_read_n, !bus.host_read_n}
                       : {!bus.high_byte_strobe, !bus.low_write_strobe};
               else
                  d.be = {!bus.high_byte_strobe, 1'b1};
               // lanes swapped at capture so the outputs stay plain flops
               if (q.big_endian)
               begin
                  d.wdata = {bus.host_data[7:0], bus.host_data[15:8]};
                  d.be = {d.be[0], d.be[1]};
               end
               d.wait_n = 1'b0;
               d.st = ST_ARB;
            end
         end
         ST_ARB:
         begin
            // refresh owns the resource: keep the host waiting
            if (refresh_req_i)
               d.cnt = 4'(BUSY_CYC);
            else if (q.cnt != 4'h0)
               d.cnt = q.cnt - 4'h1;
            else
            begin
               d.cnt = 4'(hport_pkg::ACCESS_CYC);
               d.acc = (rgn != hport_pkg::RGN_NONE);
               d.acc_we = !q.is_rd;
               d.acc_reg = (rgn == hport_pkg::RGN_REG);
               d.st = ST_XFER;
            end
         end
         ST_XFER:
         begin
            if (q.cnt != 4'h0)
               d.cnt = q.cnt - 4'h1;
            else
            begin
               // byte lanes swapped for big-endian hosts
               if (q.big_endian)
                  d.rdata = {rd_word_i[7:0], rd_word_i[15:8]};
               else
                  d.rdata = rd_word_i;
               d.wait_n = 1'b1;
               d.oe_n = !q.is_rd;
               d.st = q.is_rd ? ST_HOLD : ST_DONE;
            end
         end
         ST_HOLD:
         begin
            // data stays on the lines until the read strobe or the chip select goes away
            if (!rd_s || !cs_s)
            begin
               d.oe_n = 1'b1;
               d.st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            // wait for the host to close the cycle before the next one
            if (!rd_s && !wr_s)
               d.st = ST_IDLE;
         end
         default:
            d.st = ST_IDLE;
      endcase
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.st <= ST_IDLE;
         q.wait_n <= 1'b1;
         q.oe_n <= 1'b1;
      end
      else if (ce_i)
         q <= d;
   end

   // =========================================================
   // outputs, all from flip-flops
   assign bus.wait_n = q.wait_n;
   assign bus.dev_data_oe_n = q.oe_n;
   assign bus.dev_data_o = q.rdata;
   assign acc_o = q.acc;
   assign acc_we_o = q.acc_we;
   assign acc_reg_o = q.acc_reg;
   assign acc_addr_o = q.addr;
   assign acc_wdata_o = q.wdata;
   assign acc_be_o = q.be;
   assign mode_two_o = q.mode_two;
   assign big_endian_o = q.big_endian;
endmodule
`default_nettype wire

// File: rtl/hport_host.sv
// glue-logic end: turns simple read/write requests into generic strobes
// assumes: the same core clock; bus clock made here by dividing by two
`default_nettype none
module hport_host (
   // clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // mode, matches the controller's strap
   input wire logic mode_two_i,
   // request port
   input wire logic req_i,
   input wire logic req_we_i,
   input wire logic [16:0] req_addr_i,
   input wire logic [1:0] req_be_i,
   input wire logic [15:0] req_wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [15:0] rdata_o,
   // host bus
   hport_if.host bus
);
   typedef enum logic [2:0]
   {
      H_IDLE = 3'b001,
      H_WAIT = 3'b010,
      H_END = 3'b100
   } hst_t;
   typedef struct packed
   {
      hst_t st;
      logic bclk;
      logic cs_n, rd0_n, rd1_n, we0_n, we1_n;
      logic [16:0] addr;
      logic [15:0] wdata;
      logic doe_n;
      logic [1:0] wt;  // unused: one high wait sample after seen_lo ends the wait
      logic seen_lo;
      logic busy, done;
      logic [15:0] rdata;
   } host_t;
   host_t q, d;

   // =========================================================
   // next state
   always_comb
   begin
      d = q;
      d.bclk = !q.bclk;
      d.done = 1'b0;
      case (q.st)
         H_IDLE:
         begin
            if (req_i)
            begin
               d.addr = req_addr_i;
               d.wdata = req_wdata_i;
               d.cs_n = 1'b0;
               d.busy = 1'b1;
               d.seen_lo = 1'b0;
               if (!mode_two_i)
               begin
                  d.we0_n = !(req_we_i && req_be_i[0]);
                  d.we1_n = !(req_we_i && req_be_i[1]);
                  d.rd0_n = !(!req_we_i && req_be_i[0]);
                  d.rd1_n = !(!req_we_i && req_be_i[1]);
               end
               else
               begin
                  d.we0_n = !req_we_i;
                  d.rd0_n = req_we_i;
                  d.we1_n = !req_be_i[1];
                  d.rd1_n = 1'b1;
               end
               d.doe_n = !req_we_i;
               d.st = H_WAIT;
            end
         end
         H_WAIT:
         begin
            if (!bus.wait_n)
               d.seen_lo = 1'b1;
            if (q.seen_lo && bus.wait_n)
            begin
               d.rdata = bus.host_data;
               d.cs_n = 1'b1;
               d.rd0_n = 1'b1;
               d.rd1_n = 1'b1;
               d.we0_n = 1'b1;
               d.we1_n = 1'b1;
               d.doe_n = 1'b1;
               d.st = H_END;
            end
         end
         H_END:
         begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st = H_IDLE;
         end
         default:
            d.st = H_IDLE;
      endcase
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.st <= H_IDLE;
         q.cs_n <= 1'b1;
         q.rd0_n <= 1'b1;
         q.rd1_n <= 1'b1;
         q.we0_n <= 1'b1;
         q.we1_n <= 1'b1;
         q.doe_n <= 1'b1;
      end
      else if (ce_i)
         q <= d;
   end

   // =========================================================
   // outputs
   assign bus.host_bus_clock_in = q.bclk;
   assign bus.host_cs_n = q.cs_n;
   assign bus.host_read_n = q.rd0_n;
   assign bus.high_read_n = q.rd1_n;
   assign bus.low_write_strobe = q.we0_n;
   assign bus.high_byte_strobe = q.we1_n;
   assign bus.host_address = q.addr;
   assign bus.host_data_o = q.wdata;
   assign bus.host_data_oe_n = q.doe_n;
   assign busy_o = q.busy;
   assign done_o = q.done;
   assign rdata_o = q.rdata;
endmodule
`default_nettype wire

// File: tb/hport_assertions.sv
// checker for the host port wires between the glue end and controller end
// assumes: one clock, synchronous active-low reset, watched beside the bus
`default_nettype none
module hport_assertions (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // bus wires
   input wire logic host_cs_n,
   input wire logic host_read_n,
   input wire logic high_read_n,
   input wire logic low_write_strobe,
   input wire logic wait_n,
   input wire logic dev_data_oe_n,
   input wire logic [15:0] dev_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // wait handshake
   a_wait_needs_cs: assert property (!wait_n |-> !host_cs_n)
      else $error("wait low with no chip select");
   a_wait_min_low: assert property
      ($fell(wait_n) |-> !wait_n [*4])
      else $error("wait released too early");
   a_wait_bounded: assert property
      ($fell(wait_n) |-> ##[4:200] wait_n)
      else $error("wait never released");
   // idle bus never stalls the host; strobes pass two sync stages
   a_idle_no_wait: assert property (host_cs_n [*4] |-> wait_n)
      else $error("wait low on idle bus");
   // ==========================================================
   // read data drive
   a_oe_after_wait: assert property (!dev_data_oe_n |-> wait_n)
      else $error("data driven while waiting");
   a_data_held: assert property ((!dev_data_oe_n && !host_read_n &&
      !host_cs_n) ##1 (!host_read_n && !host_cs_n) |->
      !dev_data_oe_n && $stable(dev_data_o))
      else $error("read data not held");
   a_oe_release: assert property (($rose(host_read_n) &&
      !dev_data_oe_n) |-> ##[1:5] dev_data_oe_n)
      else $error("data lines not released");
   // ==========================================================
   // host strobes
   a_write_no_drive: assert property
      (!low_write_strobe |-> dev_data_oe_n)
      else $error("contention during write");
   a_rw_exclusive: assert property (!low_write_strobe |->
      host_read_n && high_read_n)
      else $error("read and write strobes together");
   // main scenarios
   c_read: cover property ($fell(dev_data_oe_n));
   c_write: cover property (!low_write_strobe && !wait_n);
   c_long_wait: cover property (!wait_n [*8]);
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench: controller end and glue end joined on one bus
// assumes: 40 MHz clock, straps held steady across each reset
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus and observed signals
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic mode = 1'b0;
   logic endian = 1'b0;
   logic refresh = 1'b0;
   logic [15:0] rd_word = 16'h0000;
   logic req = 1'b0;
   logic req_we = 1'b0;
   logic [16:0] req_addr = 17'h0_0000;
   logic [1:0] req_be = 2'b00;
   logic [15:0] req_wdata = 16'h0000;
   logic busy, done, acc, acc_we, acc_reg, mode_two, big_endian;
   logic [16:0] acc_addr;
   logic [15:0] acc_wdata, rdata;
   logic [1:0] acc_be;
   logic [36:0] cap = '0; // last resource access seen
   int n_acc = 0;
   int n_fail = 0;
   int compares = 0;
   always #12.5 mclk_i = ~mclk_i;
   // ==========================================================
   // the two ends and the checker
   hport_if u_hport_if ();
   // small refresh tail keeps the run short
   hport_dev #(.BUSY_CYC(1)) u_hport_dev (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .ce_i(1'b1), .bus_mode_strap_i(mode),
      .endian_strap_i(endian), .refresh_req_i(refresh),
      .rd_word_i(rd_word), .acc_o(acc), .acc_we_o(acc_we),
      .acc_reg_o(acc_reg), .acc_addr_o(acc_addr),
      .acc_wdata_o(acc_wdata), .acc_be_o(acc_be),
      .mode_two_o(mode_two), .big_endian_o(big_endian),
      .bus(u_hport_if));
   hport_host u_hport_host (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .ce_i(1'b1), .mode_two_i(mode), .req_i(req), .req_we_i(req_we),
      .req_addr_i(req_addr), .req_be_i(req_be),
      .req_wdata_i(req_wdata), .busy_o(busy), .done_o(done),
      .rdata_o(rdata), .bus(u_hport_if));
   hport_assertions u_hport_assertions (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .host_cs_n(u_hport_if.host_cs_n),
      .host_read_n(u_hport_if.host_read_n),
      .high_read_n(u_hport_if.high_read_n),
      .low_write_strobe(u_hport_if.low_write_strobe),
      .wait_n(u_hport_if.wait_n),
      .dev_data_oe_n(u_hport_if.dev_data_oe_n),
      .dev_data_o(u_hport_if.dev_data_o));
   // capture every resource access pulse, mid-cycle where it is settled
   always @(negedge mclk_i)
      if (acc === 1'b1)
      begin
         n_acc <= n_acc + 1;
         cap <= {acc_we, acc_reg, acc_be, acc_addr, acc_wdata};
      end
   // ==========================================================
   // helpers
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("counts: compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // byte swap applied by the controller in big endian
   function automatic logic [15:0] sw(input logic [15:0] w);
      return endian ? {w[7:0], w[15:8]} : w;
   endfunction
   // one request through the glue end, bounded wait for done
   task automatic xfer(input logic we, input logic [16:0] a,
      input logic [1:0] be, input logic [15:0] wd);
      int n;
      n = 0;
      @(negedge mclk_i);
      req = 1'b1;
      req_we = we;
      req_addr = a;
      req_be = be;
      req_wdata = wd;
      @(negedge mclk_i);
      req = 1'b0;
      chk(37'(busy), 37'h1);
      while (done !== 1'b1 && n < 400)
      begin
         @(negedge mclk_i);
         n++;
      end
      chk(37'(n == 400), 37'h0);
      chk(37'(busy), 37'h0);
   endtask
   task automatic start(input logic m, input logic e);
      @(negedge mclk_i);
      rst_n_i = 1'b0;
      mode = m;
      endian = e;
      repeat (5) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge mclk_i);
      chk({35'h0, mode_two, big_endian}, {35'h0, m, e});
   endtask
   // ==========================================================
   // scenarios
   task automatic t_write();
      int k;
      k = n_acc;
      xfer(1'b1, 17'h1_3FFE, 2'b11, 16'hA55A);
      chk(37'(n_acc - k), 37'h1);
      chk(cap, {2'b10, 2'b11, 17'h1_3FFE, sw(16'hA55A)});
      $display("end of word write test");
   endtask
   task automatic t_byte();
      logic [1:0] rb;
      // high lane alone; mode two always carries the low lane as well
      rb = mode ? 2'b11 : 2'b10;
      if (endian)
         rb = {rb[0], rb[1]};
      xfer(1'b1, 17'h0_0002, 2'b01, 16'h00C3);
      chk(37'(cap[34:33]), 37'(endian ? 2'b10 : 2'b01));
      chk(37'(cap[15:0]), 37'(sw(16'h00C3)));
      rd_word = 16'h1234;
      xfer(1'b0, 17'h1_FFE2, 2'b10, 16'h0000);
      chk(37'(cap[34:33]), 37'(rb));
      chk(37'(rdata), 37'(sw(16'h1234)));
      $display("end of byte access test");
   endtask
   task automatic t_read();
      rd_word = 16'h5AC3;
      xfer(1'b0, 17'h1_FFE0, 2'b11, 16'h0000);
      chk(37'(cap[36:16]), {16'h0, 2'b01, 2'b11, 17'h1_FFE0});
      chk(37'(rdata), 37'(sw(16'h5AC3)));
      $display("end of register read test");
   endtask
   task automatic t_unmapped();
      int k;
      k = n_acc;
      xfer(1'b1, 17'h1_4000, 2'b11, 16'h1111);
      chk(37'(n_acc - k), 37'h0);
      $display("end of unmapped test");
   endtask
   // refresh holds the resource: no access until it drops
   task automatic t_refresh();
      int k;
      k = n_acc;
      refresh = 1'b1;
      rd_word = 16'h0F1E;
      fork
         xfer(1'b0, 17'h0_0100, 2'b11, 16'h0000);
         begin
            repeat (30) @(negedge mclk_i);
            chk(37'(n_acc - k), 37'h0);
            refresh = 1'b0;
         end
      join
      chk(37'(n_acc - k), 37'h1);
      chk(37'(rdata), 37'(sw(16'h0F1E)));
      $display("end of refresh test");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      for (int i = 0; i < 4; i++)
      begin
         start(i[1], i[0]);
         t_write();
         t_byte();
         t_read();
         t_unmapped();
      end
      t_refresh();
      end_of_test();
   end
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
